// ---- hw/psr_pkg.sv ----
/*
  Package for the position status reporting block: word indices,
  configuration and status bit positions, command bits, mode codes,
  timing constants and the carrier structs shared by the design.
  Assumes a 40 MHz reference clock.
*/
package psr_pkg;

  // input word layout (index within the block of ten)
  localparam int unsigned WORDS_PER_CH    = 5;
  localparam int unsigned IDX_STATUS      = 0;
  localparam int unsigned IDX_POSITION    = 1;
  localparam int unsigned IDX_VELOCITY    = 2;
  localparam int unsigned IDX_CAPTURED    = 3;
  localparam int unsigned IDX_PROJECTED   = 4;
  localparam int unsigned CH2_BASE        = 5;

  // setup readback word indices
  localparam int unsigned RB_WORDS        = 8;
  localparam int unsigned RB_CONFIG       = 0;
  localparam int unsigned RB_GRADIENT     = 1;
  localparam int unsigned RB_FS_LENGTH    = 2;
  localparam int unsigned RB_FS_COUNT     = 3;
  localparam int unsigned RB_PRESET       = 4;
  localparam int unsigned RB_LIMIT_ON     = 5;
  localparam int unsigned RB_LIMIT_OFF    = 6;
  localparam int unsigned RB_OFFSET       = 7;

  // configuration bit positions
  localparam int unsigned CFG_FAULT_LATCH = 8;
  localparam int unsigned CFG_COUNT_NEG   = 9;
  localparam int unsigned CFG_VEL_FAST    = 10;
  localparam int unsigned CFG_LATCH_RISE  = 11;
  localparam int unsigned CFG_LATCH_FALL  = 12;
  localparam int unsigned CFG_UNITS       = 13;
  localparam int unsigned CFG_MODE_LO     = 14;
  localparam int unsigned CFG_MODE_HI     = 16;
  localparam logic [31:0] CFG_USED_MASK   = 32'h0001_FF00;

  // status bit positions
  localparam int unsigned ST_PRESET_ACK   = 0;
  localparam int unsigned ST_INTERP_ACK   = 1;
  localparam int unsigned ST_STOPPED      = 2;
  localparam int unsigned ST_DIR_DOWN     = 3;
  localparam int unsigned ST_LATCH_IN     = 4;
  localparam int unsigned ST_LIMIT        = 5;
  localparam int unsigned ST_INTERP_LIMIT = 6;
  localparam int unsigned ST_FAULT        = 7;
  localparam int unsigned ST_CMD_FAULT    = 14;

  // command bit positions
  localparam int unsigned CMD_PRESET      = 0;
  localparam int unsigned CMD_INTERP      = 1;
  localparam int unsigned CMD_CLR_FAULT   = 2;
  localparam logic [31:0] CMD_RSVD_MASK   = 32'hFFFF_FFF8;

  // factory setup values
  localparam logic [31:0] DEF_CONFIG      = 32'h0000_0000;
  localparam logic [31:0] DEF_GRADIENT    = 32'h0001_5F90;
  localparam logic [31:0] DEF_FS_LENGTH   = 32'h0000_0010;
  localparam logic [31:0] DEF_FS_COUNT    = 32'h0000_3E80;

  // timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned VEL_SLOW_MS     = 160;
  localparam int unsigned VEL_FAST_MS     = 60;
  localparam int unsigned VEL_SLOW_CYC    = VEL_SLOW_MS * (CLK_HZ / 1000);
  localparam int unsigned VEL_FAST_CYC    = VEL_FAST_MS * (CLK_HZ / 1000);

  typedef enum logic [3:0] {
    PSR_MODE_START_STOP = 4'h1,
    PSR_MODE_CTRL_PULSE = 4'h2,
    PSR_MODE_PWM1       = 4'h4,
    PSR_MODE_PWM2       = 4'h8
  } psr_mode_e;

  typedef struct packed {
    logic [31:0] config_bits;
    logic [31:0] gradient;
    logic [31:0] fsLength;
    logic [31:0] fsCount;
    logic [31:0] preset;
    logic [31:0] limitOn;
    logic [31:0] limitOff;
  } psr_setup_s;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] position;
    logic [31:0] velocity;
    logic [31:0] captured;
    logic [31:0] projected;
  } psr_inputs_s;

endpackage

// ---- hw/psr_status_report.sv ----
/*
  Two-channel position status reporting: setup store with readback,
  preset offset, velocity/stopped/direction tracking, edge capture,
  interpolation, limit windows and the transducer fault flag, packed
  into ten input words updated together per channel.
  Assumes raw position samples and a valid strobe come from the
  measurement front end on ref_clk; the latch pins are asynchronous.
*/
`timescale 1ns/1ps

module psr_status_report
  import psr_pkg::*;
#(
  parameter int unsigned NUM_CH    = 2,
  parameter int unsigned SLOW_CYC  = VEL_SLOW_CYC,
  parameter int unsigned FAST_CYC  = VEL_FAST_CYC
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // front end samples, one per channel
  input  wire logic [NUM_CH-1:0]     sampleValid,
  input  wire logic [NUM_CH-1:0]     sampleFault,
  input  wire logic [31:0]           sampleRaw [NUM_CH],
  input  wire logic [NUM_CH-1:0]     latchPin,
  // setup write, already checked for validity
  input  wire logic                  setupWrite,
  input  wire logic                  setupAccepted,
  input  wire logic                  setupChannel,
  input  wire psr_setup_s            setupData,
  // command output words from the controller
  input  wire logic [31:0]           cmdWord [NUM_CH],
  input  wire logic [31:0]           timeStamp [NUM_CH],
  // setup readback
  input  wire logic                  rbChannel,
  input  wire logic [2:0]            rbIndex,
  output logic [31:0]                rbData,
  // input words
  output psr_inputs_s                inWords [NUM_CH]
);

  psr_setup_s  setup_q  [NUM_CH];
  logic [31:0] offset_q [NUM_CH];
  logic [31:0] rbData_q;

  // readback mux, reserved config bits forced low
  logic [31:0] rbSel;
  psr_setup_s  rbSetup;
  assign rbSetup = setup_q[rbChannel];
  always_comb begin
    unique case (rbIndex)
      3'h0:    rbSel = rbSetup.config_bits & CFG_USED_MASK;
      3'h1:    rbSel = rbSetup.gradient;
      3'h2:    rbSel = rbSetup.fsLength;
      3'h3:    rbSel = rbSetup.fsCount;
      3'h4:    rbSel = rbSetup.preset;
      3'h5:    rbSel = rbSetup.limitOn;
      3'h6:    rbSel = rbSetup.limitOff;
      default: rbSel = offset_q[rbChannel];
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rbData_q <= 32'h0000_0000;
    end else begin
      rbData_q <= rbSel;
    end
  end
  assign rbData = rbData_q;

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      logic [1:0]  latchSync_q;
      logic        latchPrev_q;
      logic        cmdPrev_q [3];
      logic [31:0] pos_q;
      logic [31:0] lastPos_q;
      logic [31:0] periodStart_q;
      logic [31:0] vel_q;
      logic [31:0] cnt_q;
      logic        moved_q;
      logic        stopped_q;
      logic        dirDown_q;
      logic        fault_q;
      logic        interpAck_q;
      logic        interpLim_q;
      logic        applyReq_q;
      logic [31:0] captured_q;
      logic [31:0] projected_q;
      psr_inputs_s words_q;

      psr_setup_s  su;
      logic        wrThis;
      logic [31:0] scaled;
      logic [31:0] posNext;
      logic [31:0] periodCyc;
      logic        periodEnd;
      logic        lateHalf;
      logic        presetRise;
      logic        interpEdge;
      logic        clrRise;
      logic        riseEdge;
      logic        fallEdge;
      logic [63:0] prodFull;
      logic [31:0] projNext;
      logic        inLimit;
      logic        projInLimit;
      psr_mode_e   mode;

      assign su      = setup_q[c];
      assign wrThis  = setupWrite && setupAccepted
                       && (setupChannel == 1'(c));
      // negative count direction inverts the raw sample
      assign scaled  = su.config_bits[CFG_COUNT_NEG] ?
                       (32'h0000_0000 - sampleRaw[c]) : sampleRaw[c];
      assign posNext = scaled + offset_q[c];
      assign periodCyc = su.config_bits[CFG_VEL_FAST] ?
                         FAST_CYC[31:0] : SLOW_CYC[31:0];
      assign periodEnd = (cnt_q >= periodCyc - 32'h0000_0001);
      assign lateHalf  = (cnt_q >= {1'b0, periodCyc[31:1]});
      assign presetRise = cmdWord[c][CMD_PRESET] && !cmdPrev_q[0];
      assign interpEdge = cmdWord[c][CMD_INTERP] != cmdPrev_q[1];
      assign clrRise  = cmdWord[c][CMD_CLR_FAULT] && !cmdPrev_q[2];
      assign riseEdge = latchSync_q[1] && !latchPrev_q;
      assign fallEdge = !latchSync_q[1] && latchPrev_q;
      // projection: velocity in counts/s times time stamp in microseconds
      assign prodFull = $signed(vel_q) * $signed(timeStamp[c]);
      // signed divide so a negative velocity projects backwards
      assign projNext = pos_q + 32'($signed(prodFull) / 64'sd1000000);
      assign inLimit  = ($signed(pos_q) >= $signed(su.limitOn))
                        && ($signed(pos_q) <= $signed(su.limitOff));
      assign projInLimit = ($signed(projNext) >= $signed(su.limitOn))
                        && ($signed(projNext) <= $signed(su.limitOff));
      always_comb begin
        unique case (su.config_bits[CFG_MODE_HI:CFG_MODE_LO])
          3'h1:    mode = PSR_MODE_CTRL_PULSE;
          3'h2:    mode = PSR_MODE_PWM1;
          3'h3:    mode = PSR_MODE_PWM2;
          default: mode = PSR_MODE_START_STOP;
        endcase
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          setup_q[c] <= '{DEF_CONFIG, DEF_GRADIENT, DEF_FS_LENGTH,
                          DEF_FS_COUNT, 32'h0, 32'h0, 32'h0};
          offset_q[c] <= 32'h0000_0000;
        end else if (wrThis) begin
          // reserved bits stored as written, masked only on readback; units bit 13 kept as written
          setup_q[c] <= setupData;
          offset_q[c] <= 32'h0000_0000;
        end else if (applyReq_q && sampleValid[c]) begin
          offset_q[c] <= su.preset - scaled;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          latchSync_q <= 2'b00;
          latchPrev_q <= 1'b0;
          cmdPrev_q   <= '{1'b0, 1'b0, 1'b0};
        end else begin
          latchSync_q <= {latchSync_q[0], latchPin[c]};
          latchPrev_q <= latchSync_q[1];
          cmdPrev_q   <= '{cmdWord[c][CMD_PRESET], cmdWord[c][CMD_INTERP],
                           cmdWord[c][CMD_CLR_FAULT]};
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          applyReq_q <= 1'b0;
        end else begin
          applyReq_q <= presetRise || (applyReq_q && !sampleValid[c]);
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          pos_q <= 32'h0000_0000;
        end else if (sampleValid[c] && !sampleFault[c]) begin
          pos_q <= posNext;
        end
      end

      // velocity window and motion tracking
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          cnt_q <= 32'h0000_0000;
          periodStart_q <= 32'h0000_0000;
          lastPos_q <= 32'h0000_0000;
          vel_q <= 32'h0000_0000;
          moved_q <= 1'b0;
          stopped_q <= 1'b0;
          dirDown_q <= 1'b0;
        end else begin
          lastPos_q <= pos_q;
          if (pos_q != lastPos_q) begin
            // hold the last direction when nothing moves
            dirDown_q <= $signed(pos_q) < $signed(lastPos_q);
          end
          if (periodEnd) begin
            cnt_q <= 32'h0000_0000;
            periodStart_q <= pos_q;
            vel_q <= 32'((($signed(pos_q) - $signed(periodStart_q))
                         * 64'sd1000) / $signed({32'h0, periodCyc})
                         * 64'sd40000);
            stopped_q <= !moved_q;
            moved_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
            if (lateHalf && (pos_q != lastPos_q)) begin
              moved_q <= 1'b1;
            end
          end
        end
      end

      // fault: live source or latched until command, set beats clear
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          fault_q <= 1'b0;
        end else if (sampleFault[c]) begin
          fault_q <= 1'b1;
        end else if (!su.config_bits[CFG_FAULT_LATCH] || clrRise) begin
          fault_q <= 1'b0;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          captured_q <= 32'h0000_0000;
        end else if ((riseEdge && su.config_bits[CFG_LATCH_RISE])
                  || (fallEdge && su.config_bits[CFG_LATCH_FALL])) begin
          captured_q <= pos_q;
        end
      end

      // acknowledge is stored on the same edge as the projection
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          projected_q <= 32'h0000_0000;
          interpAck_q <= 1'b0;
          interpLim_q <= 1'b0;
        end else if (interpEdge) begin
          projected_q <= projNext;
          interpAck_q <= cmdWord[c][CMD_INTERP];
          interpLim_q <= projInLimit;
        end
      end

      // all five words load in one edge so a sample never mixes ages
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          words_q <= '0;
        end else begin
          words_q.status <= {17'h0,
            |(cmdWord[c] & CMD_RSVD_MASK),
            6'h0, fault_q, interpLim_q, inLimit,
            latchSync_q[1],
            dirDown_q, stopped_q, interpAck_q,
            cmdWord[c][CMD_PRESET]};
          words_q.position  <= pos_q;
          words_q.velocity  <= vel_q;
          words_q.captured  <= captured_q;
          words_q.projected <= projected_q;
        end
      end
      assign inWords[c] = words_q;
    end
  endgenerate

endmodule

// ---- tb/psr_status_checker.sv ----
/*
  Port checker for psr_status_report, bound by name below.
  Assumes synchronous active-high rst on ref_clk.
*/
`timescale 1ns/1ps
module psr_status_checker
  import psr_pkg::*;
#(
  parameter int unsigned NUM_CH = 2
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              rst,
  // driven toward the block
  input wire logic [NUM_CH-1:0] latchPin,
  input wire logic              setupWrite,
  input wire logic              setupAccepted,
  input wire logic              setupChannel,
  input wire psr_setup_s        setupData,
  input wire logic [31:0]       cmdWord [NUM_CH],
  input wire logic              rbChannel,
  input wire logic [2:0]        rbIndex,
  // driven by the block
  input wire logic [31:0]       rbData,
  input wire psr_inputs_s       inWords [NUM_CH]
);
  logic [31:0] st0;
  logic [31:0] st1;
  assign st0 = inWords[0].status;
  assign st1 = inWords[1].status;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_CFG_ZERO: assert property (
    $past(rbIndex) == RB_CONFIG |-> (rbData & ~CFG_USED_MASK) == 32'h0
  ) else $error("config readback reserved bits set");
  AST_PRESET_ACK: assert property (
    !$past(rst) |-> st0[ST_PRESET_ACK] == $past(cmdWord[0][CMD_PRESET])
  ) else $error("preset ack does not follow command");
  AST_CMD_FAULT: assert property (
    !$past(rst) |-> st0[ST_CMD_FAULT] == |($past(cmdWord[0]) & CMD_RSVD_MASK)
  ) else $error("reserved command flag wrong");
  AST_UNUSED_ZERO: assert property (
    ((st0 | st1) & 32'hFFFF_BF00) == 32'h0
  ) else $error("unused status bit set");
  AST_LATCH_IN: assert property (
    (latchPin[1] == $past(latchPin[1]))[*6] |-> st1[ST_LATCH_IN] == latchPin[1]
  ) else $error("latch mirror wrong");
  AST_INTERP_ACK: assert property (
    $changed(cmdWord[0][CMD_INTERP]) |->
      ##[1:3] st0[ST_INTERP_ACK] == cmdWord[0][CMD_INTERP]
  ) else $error("interp ack late");
  AST_RB_STORE: assert property (
    (setupWrite && setupAccepted) ##1
      (rbIndex == RB_GRADIENT && rbChannel == $past(setupChannel))
      |=> rbData == $past(setupData.gradient, 2)
  ) else $error("accepted setup not read back");
  AST_RB_REJECT: assert property (
    (setupWrite && !setupAccepted && rbIndex != RB_OFFSET) ##1
      ($stable(rbIndex) && $stable(rbChannel)) |=> $stable(rbData)
  ) else $error("rejected setup changed readback");
  AST_OFFSET_CLR: assert property (
    (setupWrite && setupAccepted) ##1
      (rbIndex == RB_OFFSET && rbChannel == $past(setupChannel))
      |=> rbData == 32'h0
  ) else $error("offset not cleared by setup");

  COV_WRITE: cover property (setupWrite && setupAccepted);
  COV_INTERP: cover property ($changed(cmdWord[0][CMD_INTERP]));
  COV_LATCH: cover property ($rose(latchPin[1]));
endmodule

bind psr_status_report psr_status_checker #(.NUM_CH(NUM_CH)) u_chk (
  .ref_clk(ref_clk),
  .rst(rst),
  .latchPin(latchPin),
  .setupWrite(setupWrite),
  .setupAccepted(setupAccepted),
  .setupChannel(setupChannel),
  .setupData(setupData),
  .cmdWord(cmdWord),
  .rbChannel(rbChannel),
  .rbIndex(rbIndex),
  .rbData(rbData),
  .inWords(inWords)
);

// ---- tb/psr_ctrl_model.sv ----
/*
  Rack controller model: registers bench command requests onto the
  output words and polls all ten input words at one edge.
  Assumes ref_clk and a synchronous active-high rst.
*/
`timescale 1ns/1ps
module psr_ctrl_model
  import psr_pkg::*;
#(
  parameter int unsigned POLL = 7
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // bench requests and block words
  input  wire logic [31:0] cmdReq [2],
  input  wire psr_inputs_s inWords [2],
  // toward the block and the bench
  output logic      [31:0] cmdWord [2],
  output logic      [31:0] timeStamp [2],
  output psr_inputs_s      polled [2]
);
  int unsigned pollCnt;
  // zero look-ahead keeps the projected value equal to position
  assign timeStamp = '{32'h0, 32'h0};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmdWord <= '{32'h0, 32'h0};
      pollCnt <= 0;
    end else begin
      cmdWord <= cmdReq;
      pollCnt <= (pollCnt == POLL - 1) ? 0 : pollCnt + 1;
      // whole block taken at one edge, unrelated to the bench flow
      if (pollCnt == 0) polled <= inWords;
    end
  end
endmodule

// ---- tb/testbench.sv ----
/*
  Self-checking bench for psr_status_report with a controller model.
  Assumes short velocity periods and a 40 MHz ref_clk.
*/
`timescale 1ns/1ps
module testbench
  import psr_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  sampleValid = 2'h0;
  logic [1:0]  sampleFault = 2'h0;
  logic [1:0]  latchPin = 2'h0;
  logic [31:0] sampleRaw [2] = '{32'h0, 32'h0};
  logic        setupWrite = 1'b0;
  logic        setupAccepted = 1'b0;
  logic        setupChannel = 1'b0;
  psr_setup_s  setupData = '0;
  logic [31:0] cmdReq [2] = '{32'h0, 32'h0};
  logic [31:0] cmdWord [2];
  logic [31:0] timeStamp [2];
  logic        rbChannel = 1'b0;
  logic [2:0]  rbIndex = 3'h0;
  logic [31:0] rbData;
  psr_inputs_s inWords [2];
  psr_inputs_s polled [2];
  int          err_total = 0;
  int          n_tests = 0;

  always #12.5 ref_clk = ~ref_clk;

  psr_status_report #(.NUM_CH(2), .SLOW_CYC(64), .FAST_CYC(24)) dut (
    .ref_clk(ref_clk), .rst(rst), .sampleValid(sampleValid),
    .sampleFault(sampleFault), .sampleRaw(sampleRaw), .latchPin(latchPin),
    .setupWrite(setupWrite), .setupAccepted(setupAccepted),
    .setupChannel(setupChannel), .setupData(setupData),
    .cmdWord(cmdWord), .timeStamp(timeStamp), .rbChannel(rbChannel),
    .rbIndex(rbIndex), .rbData(rbData), .inWords(inWords));
  psr_ctrl_model #(.POLL(7)) ctrl (
    .ref_clk(ref_clk), .rst(rst), .cmdReq(cmdReq), .inWords(inWords),
    .cmdWord(cmdWord), .timeStamp(timeStamp), .polled(polled));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // waits n edges, then steps past them so outputs have settled
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [31:0] st(input int c, input int b);
    return 32'(inWords[c].status[b]);
  endfunction

  task automatic rb(input logic c, input logic [2:0] i, input logic [31:0] e);
    @(posedge ref_clk);
    rbChannel <= c;
    rbIndex <= i;
    w(2);
    chk(rbData, e);
  endtask

  task automatic wr(input logic c, input logic a, input psr_setup_s d,
                    input logic [2:0] i);
    @(posedge ref_clk);
    setupWrite <= 1'b1;
    setupAccepted <= a;
    setupChannel <= c;
    setupData <= d;
    rbChannel <= c;
    rbIndex <= i;
    @(posedge ref_clk);
    setupWrite <= 1'b0;
  endtask

  task automatic t_defaults;
    logic [31:0] e [8];
    e = '{DEF_CONFIG, DEF_GRADIENT, DEF_FS_LENGTH, DEF_FS_COUNT, 0, 0, 0, 0};
    for (int i = 0; i < 8; i++) rb(1'b1, 3'(i), e[i]);
  endtask

  task automatic t_modes;
    psr_setup_s d;
    d = {DEF_CONFIG, DEF_GRADIENT, DEF_FS_LENGTH, DEF_FS_COUNT, 96'h0};
    for (int m = 0; m < 4; m++) begin
      d.config_bits = 32'(m) << CFG_MODE_LO;
      wr(1'b1, 1'b1, d, 3'h1);
      rb(1'b1, 3'h0, d.config_bits);
    end
    d.gradient = 32'h0001_5F91;
    wr(1'b1, 1'b0, d, 3'h1);
    rb(1'b1, 3'h1, DEF_GRADIENT);
  endtask

  task automatic t_preset;
    psr_setup_s d;
    d = {32'h0000_D900, DEF_GRADIENT, DEF_FS_LENGTH, DEF_FS_COUNT,
         32'h0000_1234, 32'h0000_1000, 32'h0000_2000};
    wr(1'b0, 1'b1, d, 3'h1);
    rb(1'b0, 3'h0, 32'h0000_D900);
    @(posedge ref_clk) cmdReq[0] <= 32'h1;
    w(4);
    chk(st(0, ST_PRESET_ACK), 32'h1);
    @(posedge ref_clk) sampleRaw[0] <= 32'h0000_0500;
    sampleValid[0] <= 1'b1;
    // first sample sets the offset, the second one shows the preset
    @(posedge ref_clk);
    @(posedge ref_clk) sampleValid[0] <= 1'b0;
    cmdReq[0] <= 32'h0;
    w(4);
    chk(inWords[0].position, 32'h0000_1234);
    chk(st(0, ST_LIMIT), 32'h1);
    chk(st(0, ST_PRESET_ACK), 32'h0);
    @(posedge ref_clk) cmdReq[0] <= 32'h2;
    w(5);
    chk(st(0, ST_INTERP_ACK), 32'h1);
    chk(inWords[0].projected, 32'h0000_1234);
    chk(st(0, ST_INTERP_LIMIT), 32'h1);
    d.limitOn = 32'h7FFF_0000;
    d.limitOff = 32'h7FFF_0000;
    wr(1'b0, 1'b1, d, 3'h7);
    rb(1'b0, 3'h7, 32'h0);
    w(4);
    chk(st(0, ST_INTERP_LIMIT), 32'h1);
    @(posedge ref_clk) cmdReq[0] <= 32'h0;
    w(5);
    chk(st(0, ST_INTERP_ACK), 32'h0);
    chk(st(0, ST_INTERP_LIMIT), 32'h0);
  endtask

  task automatic t_fault;
    @(posedge ref_clk) sampleFault <= 2'h3;
    w(4);
    chk(st(0, ST_FAULT), 32'h1);
    chk(st(1, ST_FAULT), 32'h1);
    @(posedge ref_clk) sampleFault <= 2'h0;
    w(4);
    chk(st(0, ST_FAULT), 32'h1);
    chk(st(1, ST_FAULT), 32'h0);
    @(posedge ref_clk) cmdReq[0] <= 32'h4;
    w(5);
    chk(st(0, ST_FAULT), 32'h0);
  endtask

  task automatic t_misc;
    @(posedge ref_clk) cmdReq[1] <= 32'h20;
    latchPin[1] <= 1'b1;
    latchPin[0] <= 1'b1;
    w(6);
    chk(inWords[0].captured, 32'h0000_1234);
    chk(st(0, ST_DIR_DOWN), 32'h0);
    chk(st(1, ST_CMD_FAULT), 32'h1);
    chk(st(1, ST_LATCH_IN), 32'h1);
    @(posedge ref_clk) cmdReq[1] <= 32'h0;
    w(140);
    chk(st(1, ST_CMD_FAULT), 32'h0);
    chk(st(1, ST_STOPPED), 32'h1);
    chk(inWords[1].velocity, 32'h0);
    chk(32'(polled[1].status[ST_LATCH_IN]), 32'h1);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    end_sim;
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_defaults;
    t_modes;
    t_preset;
    t_fault;
    t_misc;
    end_sim;
  end
endmodule
